// [design/nvmra_defines.vh]
// Constants for the data store register access block.
// Assumes a 200 MHz core clock; included by bare name.
`ifndef NVMRA_DEFINES_VH
`define NVMRA_DEFINES_VH
// ----------------------------------------------------------------------
// Register locations
// ----------------------------------------------------------------------
`define NVMRA_SEC0 1'b0
`define NVMRA_SEC1 1'b1
`define NVMRA_ADDR_LOW_OFF 8'h00
`define NVMRA_ADDR_HIGH_OFF 8'h01
`define NVMRA_DATA_OFF 8'h02
`define NVMRA_CTRL_OFF 8'h40
`define NVMRA_PTR_HIGH_SEC1 8'h01
// ----------------------------------------------------------------------
// Control fields and store shape
// ----------------------------------------------------------------------
`define NVMRA_B_FETCH_GO 0
`define NVMRA_B_FETCH_ARM 1
`define NVMRA_B_PROGRAM_GO 2
`define NVMRA_B_PROGRAM_ARM 3
`define NVMRA_B_PAGE_MODE 4
`define NVMRA_B_WIPE_GO 5
`define NVMRA_B_WIPE_ARM 6
`define NVMRA_B_TIME_SEL 7
`define NVMRA_RESET_BYTE 8'h00
`define NVMRA_HIGH_MASK 8'h0F
`define NVMRA_DEPTH 4096
`define NVMRA_AW 12
`define NVMRA_PAGE_BYTES 16
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// Durations in core clocks: 3.2 ms and 2.2 ms, then 3.7 ms and 3.0 ms.
// They are fixed for a 200 MHz clock; another clock needs new counts.
`define NVMRA_ERASE0_CYC 20'h9C400
`define NVMRA_WRITE0_CYC 20'h6B6C0
`define NVMRA_ERASE1_CYC 20'hB4AA0
`define NVMRA_WRITE1_CYC 20'h927C0
`define NVMRA_READ_CYC 20'h00002
`endif

// [design/nvmra_store.v]
// Nonvolatile store array model, 4096 bytes, one port.
// Assumes the caller holds address and data stable while writing.
`include "nvmra_defines.vh"
`default_nettype none
module nvmra_store
(
  // Clock
  input wire core_clk,
  // Access
  input wire [11:0] addr,
  input wire wr_en,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data
);
  reg [7:0] mem [0:`NVMRA_DEPTH-1];

  always @(posedge core_clk)
  begin
    if (wr_en)
      mem[addr] <= wr_data;
    rd_data <= mem[addr];
  end
endmodule
`default_nettype wire

// [design/nvmra_top.v]
// Register access logic for the on-chip data store.
// Assumes a CPU register port: sector, offset, strobes, data same clock.
// Operation
// - Provide a nonvolatile store of 4096 eight-bit locations.
// - Store is unmapped; reached only through address, data, control.
// - Operations run as single byte or page, per mode bit.
// - Four registers: address low, address high, data, control.
// - Address and data registers sit in sector 0, direct access.
// - Control sits at 40H sector 1, only via pointer and port.
// - Address low holds bits 7..0, read/write, clears at power-on.
// - Address high bits 3..0 read/write, clear at power-on.
// - Address high bits 7..4 read zero, writes ignored.
// - Mode zero is one byte; mode one uses 16-byte page.
// - Write trigger needs arm; hardware clears both when done.
// - Time select picks 3.2/2.2ms or 3.7/3.0ms erase/write.
`include "nvmra_defines.vh"
`default_nettype none
module nvmra_top
(
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Direct register port
  input wire reg_sector,
  input wire [7:0] reg_offset,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Indirect access selector: 1 uses pointer pair 2
  input wire ind_sel,
  input wire ind_wr,
  input wire ind_rd,
  input wire [7:0] ptr1_low_byte,
  input wire [7:0] ptr1_high_byte,
  input wire [7:0] ptr2_low_byte,
  input wire [7:0] ptr2_high_byte,
  // Status
  output wire nvm_busy
);
  // --------------------------------------------------------------------
  // Timing counts
  // --------------------------------------------------------------------
  localparam [19:0] ERASE0_CYC = `NVMRA_ERASE0_CYC;
  localparam [19:0] WRITE0_CYC = `NVMRA_WRITE0_CYC;
  localparam [19:0] ERASE1_CYC = `NVMRA_ERASE1_CYC;
  localparam [19:0] WRITE1_CYC = `NVMRA_WRITE1_CYC;

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_READ = 4'b0010;
  localparam [3:0] ST_ERASE = 4'b0100;
  localparam [3:0] ST_WRITE = 4'b1000;

  reg [7:0] nvm_addr_low_q;
  reg [3:0] nvm_addr_high_q;
  reg [7:0] nvm_data_reg_q;
  reg [7:0] nvm_ctrl_reg_q;
  reg [3:0] state_q;
  reg [19:0] timer_q;
  reg [3:0] page_cnt_q;
  reg [7:0] page_buf_q [0:`NVMRA_PAGE_BYTES-1];
  reg [3:0] buf_idx_q;
  reg [7:0] store_wdata;
  reg store_we;

  wire [7:0] ptr_low = ind_sel ? ptr2_low_byte : ptr1_low_byte;
  wire [7:0] ptr_high = ind_sel ? ptr2_high_byte : ptr1_high_byte;
  wire ctrl_hit = (ptr_low == `NVMRA_CTRL_OFF) &&
                  (ptr_high == `NVMRA_PTR_HIGH_SEC1);
  wire ctrl_wr = ind_wr && ctrl_hit;
  wire dir0 = (reg_sector == `NVMRA_SEC0);
  wire wr_low = reg_wr && dir0 && (reg_offset == `NVMRA_ADDR_LOW_OFF);
  wire wr_high = reg_wr && dir0 && (reg_offset == `NVMRA_ADDR_HIGH_OFF);
  wire wr_data = reg_wr && dir0 && (reg_offset == `NVMRA_DATA_OFF);
  wire page_mode = nvm_ctrl_reg_q[`NVMRA_B_PAGE_MODE];
  wire time_sel = nvm_ctrl_reg_q[`NVMRA_B_TIME_SEL];
  wire idle = (state_q == ST_IDLE);
  wire [11:0] base_addr = {nvm_addr_high_q, nvm_addr_low_q};
  // Page operations walk the 16-byte page that holds the base address.
  wire [11:0] store_addr = page_mode ?
                           {base_addr[11:4], page_cnt_q} : base_addr;
  wire [7:0] store_rdata;
  wire [3:0] last_idx = page_mode ? 4'hF : 4'h0;
  wire timer_done = (timer_q == 20'h00001);

  assign nvm_busy = !idle;

  // --------------------------------------------------------------------
  // Store array
  // --------------------------------------------------------------------
  nvmra_store u_store
  (
    .core_clk(core_clk),
    .addr(store_addr),
    .wr_en(store_we),
    .wr_data(store_wdata),
    .rd_data(store_rdata)
  );

  always @*
  begin
    store_we = 1'b0;
    store_wdata = 8'hFF;
    if (state_q == ST_ERASE && timer_done)
      store_we = 1'b1;
    if (state_q == ST_WRITE && timer_done)
    begin
      store_we = 1'b1;
      store_wdata = page_mode ? page_buf_q[page_cnt_q] : nvm_data_reg_q;
    end
  end

  // --------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= `NVMRA_RESET_BYTE;
    else if (ind_rd)
      reg_rdata <= ctrl_hit ? nvm_ctrl_reg_q : `NVMRA_RESET_BYTE;
    else if (reg_rd && !dir0)
      reg_rdata <= `NVMRA_RESET_BYTE;
    else if (reg_rd)
    begin
      case (reg_offset)
        `NVMRA_ADDR_LOW_OFF: reg_rdata <= nvm_addr_low_q;
        `NVMRA_ADDR_HIGH_OFF: reg_rdata <= {4'h0, nvm_addr_high_q};
        `NVMRA_DATA_OFF: reg_rdata <= nvm_data_reg_q;
        default: reg_rdata <= `NVMRA_RESET_BYTE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Address, data and page buffer
  // --------------------------------------------------------------------
  // Each data write, in either mode, is also queued into the page buffer;
  // a read cycle in page mode loads each store byte in turn into the data register, not the buffer.
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      nvm_addr_low_q <= `NVMRA_RESET_BYTE;
      nvm_addr_high_q <= 4'h0;
      nvm_data_reg_q <= `NVMRA_RESET_BYTE;
      buf_idx_q <= 4'h0;
    end
    else
    begin
      if (wr_low)
        nvm_addr_low_q <= reg_wdata;
      if (wr_high)
        nvm_addr_high_q <= reg_wdata[3:0];
      if (wr_data)
      begin
        nvm_data_reg_q <= reg_wdata;
        buf_idx_q <= buf_idx_q + 4'h1;
      end
      if (state_q == ST_READ && timer_done)
        nvm_data_reg_q <= store_rdata;
      if (state_q == ST_WRITE && timer_done && page_cnt_q == last_idx)
        buf_idx_q <= 4'h0;
    end
  end

  always @(posedge core_clk)
  begin
    if (wr_data)
      page_buf_q[buf_idx_q] <= reg_wdata;
  end

  // --------------------------------------------------------------------
  // Control register and cycle sequencer
  // --------------------------------------------------------------------
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      nvm_ctrl_reg_q <= `NVMRA_RESET_BYTE;
      state_q <= ST_IDLE;
      timer_q <= 20'h00000;
      page_cnt_q <= 4'h0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          page_cnt_q <= 4'h0;
          if (ctrl_wr)
          begin
            // Trigger bits only stick when their arm bit is set in the
            // same write or was already set.
            nvm_ctrl_reg_q <= reg_wdata &
              ~{2'b00, ~(reg_wdata[6] | nvm_ctrl_reg_q[6]), 2'b00,
                ~(reg_wdata[3] | nvm_ctrl_reg_q[3]), 1'b0,
                ~(reg_wdata[1] | nvm_ctrl_reg_q[1])};
            if (reg_wdata[`NVMRA_B_WIPE_GO] &&
                (reg_wdata[6] || nvm_ctrl_reg_q[6]))
            begin
              state_q <= ST_ERASE;
              timer_q <= reg_wdata[7] ? ERASE1_CYC : ERASE0_CYC;
            end
            else if (reg_wdata[`NVMRA_B_PROGRAM_GO] &&
                     (reg_wdata[3] || nvm_ctrl_reg_q[3]))
            begin
              state_q <= ST_WRITE;
              timer_q <= reg_wdata[7] ? WRITE1_CYC : WRITE0_CYC;
            end
            else if (reg_wdata[`NVMRA_B_FETCH_GO] &&
                     (reg_wdata[1] || nvm_ctrl_reg_q[1]))
            begin
              state_q <= ST_READ;
              timer_q <= `NVMRA_READ_CYC;
            end
          end
        end
        ST_READ, ST_ERASE, ST_WRITE:
        begin
          // Go bits are held; only non-trigger fields take writes.
          if (ctrl_wr)
            nvm_ctrl_reg_q <= {reg_wdata[7:6], nvm_ctrl_reg_q[5],
              reg_wdata[4:3], nvm_ctrl_reg_q[2], reg_wdata[1],
              nvm_ctrl_reg_q[0]};
          if (!timer_done)
            timer_q <= timer_q - 20'h00001;
          else if (page_cnt_q != last_idx)
          begin
            page_cnt_q <= page_cnt_q + 4'h1;
            if (state_q == ST_READ)
              timer_q <= `NVMRA_READ_CYC;
            else if (state_q == ST_ERASE)
              timer_q <= time_sel ? ERASE1_CYC : ERASE0_CYC;
            else
              timer_q <= time_sel ? WRITE1_CYC : WRITE0_CYC;
          end
          else
          begin
            state_q <= ST_IDLE;
            if (state_q == ST_ERASE)
              nvm_ctrl_reg_q[6:5] <= 2'b00;
            else if (state_q == ST_WRITE)
              nvm_ctrl_reg_q[3:2] <= 2'b00;
            else
              nvm_ctrl_reg_q[0] <= 1'b0;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [testbench/nvmra_props.sv]
// Port-level checker for the store register access block.
// Assumes it is bound to nvmra_top and sees only that module's ports.
`default_nettype none
module nvmra_props
(
  // Clock, reset and direct port
  input wire logic core_clk, sys_rst, reg_sector, reg_wr, reg_rd,
  input wire logic [7:0] reg_offset, reg_wdata, reg_rdata,
  // Indirect port and status
  input wire logic ind_sel, ind_wr, ind_rd, nvm_busy,
  input wire logic [7:0] ptr1_low_byte, ptr1_high_byte,
  input wire logic [7:0] ptr2_low_byte, ptr2_high_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire [7:0] lo = ind_sel ? ptr2_low_byte : ptr1_low_byte;
  wire [7:0] hi = ind_sel ? ptr2_high_byte : ptr1_high_byte;
  wire [7:0] w = reg_wdata;
  wire ok = lo == 8'h40 && hi == 8'h01;
  wire wr_go = w[2] & w[3] | w[5] & w[6];
  wire go = w[0] & w[1] | wr_go;
  wire cw = ind_wr && ok && !nvm_busy;
  // Arm bits stay set between writes, and hardware may clear them, so
  // this shadow is an upper bound: used only where a superset is safe.
  logic [2:0] arm_q;
  always @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      arm_q <= 3'h0;
    else if (ind_wr && ok)
      arm_q <= {w[6], w[3], w[1]};
  wire long_any = w[2] & (w[3] | arm_q[1]) | w[5] & (w[6] | arm_q[2]);
  wire go_any = w[0] & (w[1] | arm_q[0]) | long_any;
  rst_quiet_a: assert property ($fell(sys_rst) |-> !nvm_busy)
    else $error("busy set after reset");
  unarmed_go_a: assert property (cw && !go_any |=> !nvm_busy)
    else $error("cycle started without arm");
  armed_go_a: assert property (cw && go |=> nvm_busy)
    else $error("armed trigger did not start");
  bad_ptr_a: assert property (ind_wr && !ok && !nvm_busy |=> !nvm_busy)
    else $error("wrong pointer reached control");
  busy_cause_a: assert property ($rose(nvm_busy)
    |-> $past(cw && go_any)) else $error("busy rose without trigger");
  read_short_a: assert property (cw && w[1:0] == 2'b11 && !w[4]
    && !long_any |=> nvm_busy ##[1:4] !nvm_busy)
    else $error("read cycle length");
  write_long_a: assert property (cw && wr_go |=> nvm_busy[*8])
    else $error("program cycle too short");
  high_zero_a: assert property (reg_rd && !ind_rd && !reg_sector
    && reg_offset == 8'h01 |=> reg_rdata[7:4] == 4'h0) else $error("high");
  unmapped_a: assert property (reg_rd && !ind_rd && (reg_sector
    || reg_offset > 8'h02) |=> reg_rdata == 8'h00) else $error("unmapped");
  cover property (cw && go);
  cover property ($fell(nvm_busy));
  cover property (ind_rd && ok);
  cover property (cw && w[4] && w[1:0] == 2'b11);
endmodule
bind nvmra_top nvmra_props u_props (.core_clk, .sys_rst, .reg_sector,
  .reg_wr, .reg_rd, .reg_offset, .reg_wdata, .reg_rdata, .ind_sel, .ind_wr,
  .ind_rd, .nvm_busy, .ptr1_low_byte, .ptr1_high_byte, .ptr2_low_byte,
  .ptr2_high_byte);
`default_nettype wire

// [testbench/data_eeprom_register_access_tb_top.sv]
// Self-checking bench for the store register access block.
// Assumes the design files are compiled first; drives all ports itself.
`default_nettype none
module data_eeprom_register_access_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, sys_rst = 1, reg_sector = 0, reg_wr = 0, reg_rd = 0;
  logic ind_sel = 0, ind_wr = 0, ind_rd = 0;
  logic [7:0] reg_offset = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [7:0] ptr1_low_byte = 8'h40, ptr1_high_byte = 8'h01;
  logic [7:0] ptr2_low_byte = 8'h40, ptr2_high_byte = 8'h01;
  wire nvm_busy;
  int fail_count = 0, cmp_count = 0;
  logic [31:0] seed = 32'h00007CF6;
  nvmra_top u_dut (.core_clk, .sys_rst, .reg_sector, .reg_offset, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .ind_sel, .ind_wr, .ind_rd,
    .ptr1_low_byte, .ptr1_high_byte, .ptr2_low_byte, .ptr2_high_byte,
    .nvm_busy);
  initial forever #2.5 core_clk = ~core_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input string n, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d, errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One pulse; the extra edge lets registered read data land.
  task automatic dir(input logic w, s, input logic [7:0] o, d);
    @(posedge core_clk);
    {reg_sector, reg_offset, reg_wdata} <= {s, o, d};
    {reg_wr, reg_rd} <= {w, !w};
    @(posedge core_clk);
    {reg_wr, reg_rd} <= 2'b00;
    @(posedge core_clk);
    #1;
  endtask
  task automatic ind(input logic w, sel, input logic [7:0] lo, hi, d);
    @(posedge core_clk);
    {ind_sel, reg_wdata, ind_wr, ind_rd} <= {sel, d, w, !w};
    if (sel)
      {ptr2_low_byte, ptr2_high_byte} <= {lo, hi};
    else
      {ptr1_low_byte, ptr1_high_byte} <= {lo, hi};
    @(posedge core_clk);
    {ind_wr, ind_rd} <= 2'b00;
    @(posedge core_clk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int waited;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      dir(1'b0, 1'b0, 8'(i), 8'h00);
      chk("reset value", reg_rdata, 8'h00);
    end
    repeat (20)
    begin
      seed = xs(seed);
      dir(1'b1, 1'b0, 8'h00, seed[7:0]);
      dir(1'b1, 1'b0, 8'h01, seed[15:8] | 8'hF0);
      dir(1'b1, 1'b0, 8'h02, seed[23:16]);
      dir(1'b0, 1'b0, 8'h00, 8'h00);
      chk("addr low", reg_rdata, seed[7:0]);
      dir(1'b0, 1'b0, 8'h01, 8'h00);
      chk("addr high", reg_rdata, seed[15:8] & 8'h0F);
      dir(1'b0, 1'b0, 8'h02, 8'h00);
      chk("data", reg_rdata, seed[23:16]);
    end
    dir(1'b1, 1'b1, 8'h40, 8'h10);
    dir(1'b0, 1'b1, 8'h40, 8'h00);
    chk("direct control", reg_rdata, 8'h00);
    dir(1'b0, 1'b0, 8'h03, 8'h00);
    chk("unmapped", reg_rdata, 8'h00);
    ind(1'b1, 1'b0, 8'h41, 8'h01, 8'h10);
    ind(1'b1, 1'b1, 8'h40, 8'h00, 8'h10);
    ind(1'b0, 1'b1, 8'h40, 8'h01, 8'h00);
    chk("bad pointer", reg_rdata, 8'h00);
    ind(1'b1, 1'b0, 8'h40, 8'h01, 8'h90);
    ind(1'b0, 1'b1, 8'h40, 8'h01, 8'h00);
    chk("control mode", reg_rdata, 8'h90);
    ind(1'b1, 1'b0, 8'h40, 8'h01, 8'h25);
    chk("unarmed busy", {7'h00, nvm_busy}, 8'h00);
    ind(1'b0, 1'b0, 8'h40, 8'h01, 8'h00);
    chk("unarmed control", reg_rdata, 8'h00);
    ind(1'b1, 1'b0, 8'h40, 8'h01, 8'h03);
    for (int n = 0; n < 10 && nvm_busy !== 1'b0; n++)
      @(posedge core_clk);
    #1;
    chk("read finished", {7'h00, nvm_busy}, 8'h00);
    ind(1'b0, 1'b0, 8'h40, 8'h01, 8'h00);
    chk("read go clear", reg_rdata & 8'h01, 8'h00);
    // A page read walks 16 bytes at two clocks each.
    ind(1'b1, 1'b0, 8'h40, 8'h01, 8'h13);
    waited = 1;
    while (nvm_busy === 1'b1 && waited < 40)
    begin
      @(posedge core_clk);
      #1;
      waited++;
    end
    chk("page read cycles", 8'(waited), 8'h20);
    ind(1'b1, 1'b0, 8'h40, 8'h01, 8'h0C);
    ind(1'b1, 1'b1, 8'h40, 8'h01, 8'h63);
    repeat (1000) @(posedge core_clk);
    #1;
    chk("program busy", {7'h00, nvm_busy}, 8'h01);
    ind(1'b0, 1'b0, 8'h40, 8'h01, 8'h00);
    chk("busy triggers", reg_rdata & 8'h25, 8'h04);
    sys_rst <= 1'b1;
    @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk("reset busy", {7'h00, nvm_busy}, 8'h00);
    dir(1'b0, 1'b0, 8'h01, 8'h00);
    chk("reset high", reg_rdata, 8'h00);
    print_verdict();
  end
  // A hang is cut short here and counted as a mismatch.
  initial
  begin
    #60us;
    fail_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
